// *** logic/lcdi_init.sv ***
// Power-on initialization sequencer for a character display controller
`timescale 1ns/1ps
`include "lcdi_params.svh"

// What this block does
// - Reset sets bus width to 8-bit, held through the sequence.
// - Reset sets single-line display mode.
// - Display, cursor and blink all switched off.
// - Address step direction set to increment.
// - Whole-display shift on write disabled.
// - Every display RAM location filled with space.
// - Busy indicator high throughout the initialization.
module lcdi_init
    import lcdi_pkg::*;
(
    // Clock and reset
    input  wire logic                      i_clk,
    input  wire logic                      i_reset_n,
    input  wire logic                      i_clk_en,
    // Host instruction side: loads new settings after init
    input  wire logic                      i_cfg_load,
    input  wire lcdi_cfg_t                 i_cfg,
    // Display RAM port: host write and display read
    input  wire logic                      i_ram_we,
    input  wire logic [`LCDI_ADDR_W-1:0]   i_ram_addr,
    input  wire logic [7:0]                i_ram_wdata,
    output logic [7:0]                     o_ram_rdata,
    // Status
    output lcdi_cfg_t                      o_cfg,
    output logic                           o_busy_indicator,
    output logic                           o_init_done
);
    // Display RAM storage
    logic [7:0]              display_data_ram [0:`LCDI_RAM_DEPTH-1];

    // Sequencer state
    lcdi_state_t             state_r;
    lcdi_state_t             state_nxt;
    logic [`LCDI_ADDR_W-1:0] clr_addr_r;
    logic [`LCDI_ADDR_W-1:0] clr_addr_nxt;
    logic                    clr_last;
    logic                    init_run;
    logic                    init_fin;

    // Host access qualifiers
    logic                    addr_ok;
    logic                    host_wr;
    logic                    host_rd;
    logic                    host_load;

    // Shared RAM write port
    logic                    wr_en;
    logic [`LCDI_ADDR_W-1:0] wr_addr;
    logic [7:0]              wr_data;
    logic [`LCDI_RAM_DEPTH-1:0] wr_sel;

    // Output registers
    logic [7:0]              rdata_r;
    lcdi_cfg_t               cfg_r;

    // Phase decode from the state register
    assign init_run = (state_r == LCDI_CLEAR);
    assign init_fin = (state_r == LCDI_DONE);
    assign clr_last = (clr_addr_r == `LCDI_LAST_ADDR);

    // Addresses above the single-line range are dropped silently
    assign addr_ok   = (i_ram_addr <= `LCDI_LAST_ADDR);

    // Host requests count only once the clear pass is over
    assign host_wr   = init_fin && i_ram_we && addr_ok;
    assign host_rd   = init_fin && addr_ok;
    assign host_load = init_fin && i_cfg_load;

    // Next-state logic of the sequencer
    always_comb
    begin
        state_nxt    = state_r;
        clr_addr_nxt = clr_addr_r;
        unique case (state_r)
            LCDI_IDLE:
                state_nxt = LCDI_CLEAR;
            LCDI_CLEAR:
            begin
                clr_addr_nxt = clr_addr_r + `LCDI_ADDR_STEP;
                if (clr_last)
                    state_nxt = LCDI_DONE;
            end
            LCDI_DONE:
                state_nxt = LCDI_DONE;
            default:
                state_nxt = LCDI_IDLE;
        endcase
    end

    // Idle one cycle after reset release, then clear, then done
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            state_r <= LCDI_IDLE;
        else if (i_clk_en)
            state_r <= state_nxt;
    end

    // Clear pointer walks the RAM one word per cycle
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            clr_addr_r <= `LCDI_ADDR_RST;
        else if (i_clk_en)
            clr_addr_r <= clr_addr_nxt;
    end

    // The clear pass owns the write port; host writes wait for done
    always_comb
    begin
        wr_en   = 1'b0;
        wr_addr = i_ram_addr;
        wr_data = i_ram_wdata;
        if (init_run)
        begin
            wr_en   = 1'b1;
            wr_addr = clr_addr_r;
            wr_data = `LCDI_SPACE_CODE;
        end
        else if (host_wr)
        begin
            wr_en = 1'b1;
        end
    end

    // RAM has no reset, so each entry is loaded by the clear pass
    genvar g;
    generate
        for (g = 0; g < `LCDI_RAM_DEPTH; g++)
        begin : gen_entry
            assign wr_sel[g] = wr_en && (wr_addr == 7'(g));

            always_ff @(posedge i_clk)
            begin
                if (i_clk_en && wr_sel[g])
                    display_data_ram[g] <= wr_data;
            end
        end
    endgenerate

    // Registered read; a read during a write returns the old word
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            rdata_r <= `LCDI_RDATA_RST;
        else if (i_clk_en && host_rd)
            rdata_r <= display_data_ram[i_ram_addr];
    end

    // Defaults hold from reset; host loads ignored while busy
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            cfg_r.bus_width_sel <= `LCDI_BUS8_RST;
            cfg_r.two_lines     <= `LCDI_LINES2_RST;
            cfg_r.font_5x11     <= `LCDI_FONT11_RST;
            cfg_r.display_on    <= `LCDI_DISP_RST;
            cfg_r.cursor_on     <= `LCDI_CURS_RST;
            cfg_r.blink_on      <= `LCDI_BLINK_RST;
            cfg_r.addr_inc      <= `LCDI_INC_RST;
            cfg_r.display_shift <= `LCDI_SHIFT_RST;
        end
        else if (i_clk_en && host_load)
            cfg_r <= i_cfg;
    end

    // Data outputs straight from their registers
    assign o_ram_rdata      = rdata_r;
    assign o_cfg            = cfg_r;

    // Status follows the state register with no extra delay
    assign o_busy_indicator = !init_fin;
    assign o_init_done      = init_fin;
endmodule

// *** logic/lcdi_params.svh ***
// Constants for the display controller power-on initializer
`ifndef LCDI_PARAMS_SVH
`define LCDI_PARAMS_SVH
`define LCDI_RAM_DEPTH      80
`define LCDI_ADDR_W         7
`define LCDI_SPACE_CODE     8'h20
`define LCDI_LAST_ADDR      7'h4f
`define LCDI_BUS8_RST       1'b1
`define LCDI_LINES2_RST     1'b0
`define LCDI_FONT11_RST     1'b0
`define LCDI_DISP_RST       1'b0
`define LCDI_CURS_RST       1'b0
`define LCDI_BLINK_RST      1'b0
`define LCDI_INC_RST        1'b1
`define LCDI_SHIFT_RST      1'b0
`define LCDI_RDATA_RST      8'h00
`define LCDI_ADDR_STEP      7'h01
`define LCDI_ADDR_RST       7'h00
`endif

// *** logic/lcdi_pkg.sv ***
// Types for the display controller power-on initializer
package lcdi_pkg;
    typedef struct packed {
        logic bus_width_sel;
        logic two_lines;
        logic font_5x11;
        logic display_on;
        logic cursor_on;
        logic blink_on;
        logic addr_inc;
        logic display_shift;
    } lcdi_cfg_t;

    typedef enum logic [1:0] {
        LCDI_IDLE  = 2'b00,
        LCDI_CLEAR = 2'b01,
        LCDI_DONE  = 2'b10
    } lcdi_state_t;
endpackage

// *** verif/lcdi_init_properties.sv ***
// Port assertions for the power-on initializer
`timescale 1ns/1ps
module lcdi_chk import lcdi_pkg::*; (
    input wire logic      i_clk, i_reset_n, i_clk_en, i_cfg_load, i_ram_we, o_busy_indicator, o_init_done,
    input wire logic [6:0] i_ram_addr,
    input wire logic [7:0] i_ram_wdata, o_ram_rdata,
    input wire lcdi_cfg_t  i_cfg, o_cfg
);
    wire b = o_busy_indicator;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    property p_bus8; b |-> o_cfg.bus_width_sel; endproperty
    a_bus8: assert property (p_bus8) else $error("bus width");
    property p_n; b |-> !o_cfg.two_lines; endproperty
    a_n: assert property (p_n) else $error("lines");
    property p_dcb; b |-> o_cfg[4:2] == 3'h0; endproperty
    a_dcb: assert property (p_dcb) else $error("display flags");
    property p_id; b |-> o_cfg.addr_inc; endproperty
    a_id: assert property (p_id) else $error("step");
    property p_s; b |-> !o_cfg.display_shift; endproperty
    a_s: assert property (p_s) else $error("shift");
    property p_f; b |-> !o_cfg.font_5x11; endproperty
    a_f: assert property (p_f) else $error("font");
    property p_up; !$past(i_reset_n) |-> b && !o_init_done; endproperty
    a_up: assert property (p_up) else $error("busy at start");
    property p_hold; b ##1 b |-> $stable(o_cfg); endproperty
    a_hold: assert property (p_hold) else $error("load while busy");
    c_end: cover property ($fell(b));
    c_load: cover property (!b && i_cfg_load);
    c_wr: cover property (!b && i_ram_we);
endmodule
bind lcdi_init lcdi_chk i_chk (.*);

// *** verif/lcdi_host.sv ***
// Host model that re-initialises the controller after power-on
`timescale 1ns/1ps
module lcdi_host import lcdi_pkg::*; (
    input wire logic i_clk, i_reset_n, i_busy,
    output logic     o_cfg_load,
    output lcdi_cfg_t o_cfg
);
    logic [1:0] st_r;
    assign o_cfg = 8'h7d;
    // First try lands while busy and is refused, so a second follows
    always_ff @(posedge i_clk or negedge i_reset_n)
        if (!i_reset_n)
            {st_r, o_cfg_load} <= 3'h0;
        else
            {st_r, o_cfg_load} <= {st_r + {1'b0, o_cfg_load}, !o_cfg_load && (st_r == 2'h0 || st_r == 2'h1 && !i_busy)};
endmodule

// *** verif/tb_top.sv ***
// Testbench for the power-on initializer
`timescale 1ns/1ps
`define CHK(n,e,s) begin compares++; if ((s) !== (e)) begin error_cnt++; $display("unexpected %s %h %h", n, e, s); end end
module tb_top;
    logic clk = 0, rst_n = 0, load, we = 0, busy, en = 1;
    logic [6:0] addr = 7'h00;
    logic [7:0] wd = 8'h00, rd;
    lcdi_pkg::lcdi_cfg_t cfg, ocfg;
    int error_cnt = 0, compares = 0, n = 0;
    initial forever #20 clk = ~clk;
    lcdi_host i_host (.i_clk(clk), .i_reset_n(rst_n), .i_busy(busy), .o_cfg_load(load), .o_cfg(cfg));
    lcdi_init i_dut (.i_clk(clk), .i_reset_n(rst_n), .i_clk_en(en), .i_cfg_load(load), .i_cfg(cfg), .i_ram_we(we),
        .i_ram_addr(addr), .i_ram_wdata(wd), .o_ram_rdata(rd), .o_cfg(ocfg), .o_busy_indicator(busy), .o_init_done());
    task finish_test;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task rd_chk(input logic [6:0] a, input logic [7:0] e);
        @(posedge clk) addr <= a;
        @(posedge clk) #1 `CHK("rdata", e, rd)
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        while (n < 200 && busy !== 1'b0) @(posedge clk) #1 n++;
        `CHK("busy cycles", 81, n)
        if (n >= 200) finish_test();
        `CHK("cfg", 8'h82, ocfg)
        for (int a = 0; a < 80; a++) rd_chk(a[6:0], 8'h20);
        @(posedge clk) {addr, wd, we} <= {7'h4f, 8'h5a, 1'b1};
        @(posedge clk) we <= 1'b0;
        rd_chk(7'h4f, 8'h5a);
        `CHK("cfg", 8'h7d, ocfg)
        @(posedge clk) {en, addr} <= {1'b0, 7'h00};
        @(posedge clk) #1 `CHK("rdata frozen", 8'h5a, rd)
        finish_test();
    end
endmodule
